// *** compare_timer_pkg.sv ***
// shared constants of the compare timer block: offsets, field positions, reset values
package compare_timer_pkg;
    // ************************************************
    // register byte offsets
    // ************************************************
    localparam int ADDR_W = 6; // decoded address bits
    localparam logic [5:0] OFS_FIRST_CONTROL_LOW = 6'h00; // enable, width, one-shot
    localparam logic [5:0] OFS_FIRST_CONTROL_HIGH = 6'h04; // postscaler, sync, special event
    localparam logic [5:0] OFS_SECOND_CONTROL_HIGH = 6'h08; // output alignment
    localparam logic [5:0] OFS_COUNT_LOW_HALF = 6'h0c; // timer low half
    localparam logic [5:0] OFS_COUNT_HIGH_HALF = 6'h10; // timer high half
    localparam logic [5:0] OFS_PERIOD_LOW_HALF = 6'h14; // period low half
    localparam logic [5:0] OFS_PERIOD_HIGH_HALF = 6'h18; // period high half
    localparam logic [5:0] OFS_COMPARE_VALUE_A = 6'h1c; // compare value
    localparam logic [5:0] OFS_STATUS = 6'h20; // flags and trigger
    // ************************************************
    // field positions
    // ************************************************
    localparam int BIT_ENABLE = 15; // first_control_low: module on
    localparam int BIT_WIDE = 5; // first_control_low: wide_counter_select
    localparam int BIT_ONE_SHOT = 4; // first_control_low: one-shot compare
    localparam int BIT_SPECIAL = 7; // first_control_high: special event select
    localparam int POST_HI = 11; // first_control_high: postscaler msb
    localparam int POST_LO = 8; // first_control_high: postscaler lsb
    localparam int SYNC_HI = 4; // first_control_high: sync source msb
    localparam int SYNC_LO = 0; // first_control_high: sync source lsb
    localparam int BIT_ALIGN = 15; // second_control_high: output_timebase_align_enable
    localparam int ST_ARMED = 0; // status: trigger armed (write 1 arms)
    localparam int ST_ROLL = 1; // status: rollover flag (write 1 clears)
    localparam int ST_CMP = 2; // status: compare flag (write 1 clears)
    localparam int ST_PIN = 3; // status: compare_output_pin level
    localparam int ST_DISARM = 4; // status: write 1 clears the trigger
    // ************************************************
    // reset and encoding values
    // ************************************************
    localparam logic [15:0] RST_HALF = 16'h0000; // counts, controls, compare
    localparam logic [15:0] RST_PERIOD = 16'hffff; // period halves
    localparam logic [4:0] SYNC_FREE = 5'h00; // free period matching
    localparam logic [31:0] FULL_ONES = 32'hffffffff; // 32-bit wrap point
    localparam logic [1:0] RESP_OKAY = 2'h0; // bus answer ok
    localparam logic [1:0] RESP_SLVERR = 2'h2; // bus answer unmapped
endpackage : compare_timer_pkg

// *** event_postscaler.sv ***
// postscaler that passes one of every (limit+1) event ticks
`timescale 1ns/1ns
module event_postscaler #(
    parameter int CNT_W = 4 // postscaler field width
) (
    input wire logic clk, // time base clock
    input wire logic nrst, // async reset, active low
    input wire logic tick, // one event in
    input wire logic clear, // restart the count
    input wire logic [CNT_W-1:0] limit, // pass every limit+1 ticks
    output logic fire // one event out, same cycle as tick
);
    logic [CNT_W-1:0] count; // ticks seen so far
    logic [CNT_W-1:0] next_count; // next tick count

    // ************************************************
    // count ticks and fire on the last one
    // ************************************************
    always_comb begin
        fire = tick && (count == limit);
        next_count = count;
        if (clear || fire) begin
            next_count = '0;
        end else if (tick) begin
            next_count = count + 1'b1;
        end
    end

    // register the count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule : event_postscaler

// *** compare_timer.sv ***
// compare timer with 32-bit cascade, special event trigger and aligned output
// Contract
// RQ1: aligned output may miss first period; here pendToggle lands on the first period edge, so no period is missed
// RQ2: aligned output correct from second period
// RQ3: special event ignores interrupt postscaler
// RQ4: special event pulses every compare match
// RQ5: wide bit cascades halves into 32 bits
// RQ6: sync value zero means free period match
// RQ7: no early rollover on low half wrap
// RQ8: high-start timer rolls over at all ones
// RQ9: one-shot zero compare gives extra event; here matchFire needs armed, so no extra event
// RQ10: software loads nonzero compare value A
// RQ11: rollover clears count, sets flag together
`timescale 1ns/1ns
module compare_timer (
    input wire logic clk, // 50 MHz time base clock
    input wire logic nrst, // async reset, active low
    input wire logic syncPin, // external sync source pin
    input wire logic [31:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte enables
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [31:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    output logic compareOutputPin, // compare_output_pin
    output logic specialEventPulse, // special event trigger, one cycle
    output logic compareEvent, // compare interrupt event, one cycle
    output logic rolloverEvent // timer rollover interrupt event, one cycle
);
    import compare_timer_pkg::*;

    // ************************************************
    // declarations
    // ************************************************
    logic syncMeta, syncSafe, syncLast; // sync pin synchroniser and edge memory
    logic [ADDR_W-1:0] wAddr, rAddr; // held bus addresses
    logic [31:0] wData; // held write data
    logic [3:0] wStrb; // held byte enables
    logic awHeld, wHeld; // address or data captured
    logic [15:0] firstControlLow, firstControlHigh, secondControlHigh; // controls
    logic [15:0] countLowHalf, countHighHalf, periodLowHalf, periodHighHalf; // time base
    logic [15:0] compareValueA; // compare value
    logic armed, rollFlag, cmpFlag, pendToggle; // trigger, sticky flags, aligned toggle
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid; // bus next
    logic next_awHeld, next_wHeld; // holding next
    logic [ADDR_W-1:0] next_wAddr; // held address next
    logic [31:0] next_wData, next_rdata; // data next
    logic [3:0] next_wStrb; // strobes next
    logic [1:0] next_bresp, next_rresp; // responses next
    logic [15:0] next_ctlLow, next_ctlHigh, next_ctl2High; // controls next
    logic [15:0] next_cntLow, next_cntHigh, next_perLow, next_perHigh, next_cmpA; // values next
    logic next_armed, next_rollFlag, next_cmpFlag, next_pendToggle, next_pin; // state next
    logic next_special, next_compareEvent, next_rollover; // event outputs next
    logic doWrite, wrHit; // write performed now, address mapped
    logic running, wide, oneShot, specialSel, alignOn; // decoded controls
    logic [31:0] fullCount, fullPeriod; // cascaded views
    logic periodHit, wrapHit, rollNow, matchFire, postFire, syncRise; // time base events

    // merge a 16-bit register with byte-enabled write data
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // ************************************************
    // sync pin crossing
    // ************************************************
    // two flops before use, third remembers the last level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syncMeta <= 1'b0;
            syncSafe <= 1'b0;
            syncLast <= 1'b0;
        end else begin
            syncMeta <= syncPin;
            syncSafe <= syncMeta;
            syncLast <= syncSafe;
        end
    end

    // ************************************************
    // decoded controls and time base events
    // ************************************************
    assign running = firstControlLow[BIT_ENABLE];
    assign wide = firstControlLow[BIT_WIDE]; // RQ5
    assign oneShot = firstControlLow[BIT_ONE_SHOT];
    assign specialSel = firstControlHigh[BIT_SPECIAL];
    assign alignOn = secondControlHigh[BIT_ALIGN];
    assign fullCount = {countHighHalf, countLowHalf}; // RQ5
    assign fullPeriod = {periodHighHalf, periodLowHalf};
    assign syncRise = syncSafe && !syncLast;
    // period match counts only with free matching selected
    assign periodHit = (firstControlHigh[SYNC_HI:SYNC_LO] == SYNC_FREE) && // RQ6
                       (wide ? (fullCount == fullPeriod) : (countLowHalf == periodLowHalf));
    // wide mode wraps only at all ones, never at the low half wrap
    assign wrapHit = wide ? (fullCount == FULL_ONES) : (countLowHalf == FULL_ONES[15:0]); // RQ7 RQ8
    assign rollNow = running && (periodHit || wrapHit ||
                     ((firstControlHigh[SYNC_HI:SYNC_LO] != SYNC_FREE) && syncRise));
    // one-shot fires only while armed, so a cleared trigger makes no stray event
    assign matchFire = running && (countLowHalf == compareValueA) && (!oneShot || armed); // RQ9
    assign doWrite = awHeld && wHeld && !bvalid;
    assign wrHit = (wAddr <= OFS_STATUS) && (wAddr[1:0] == 2'h0);

    // compare interrupt postscaler, bypassed under special event
    event_postscaler #(.CNT_W(POST_HI - POST_LO + 1)) postscaler (
        .clk(clk),
        .nrst(nrst),
        .tick(matchFire && !specialSel), // RQ3
        .clear(!running || specialSel),
        .limit(firstControlHigh[POST_HI:POST_LO]),
        .fire(postFire)
    );

    // ************************************************
    // bus slave next values
    // ************************************************
    always_comb begin
        next_awready = awready;
        next_wready = wready;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_wAddr = wAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        // capture address and data in either order
        if (awvalid && awready) begin
            next_awHeld = 1'b1;
            next_awready = 1'b0;
            next_wAddr = awaddr[ADDR_W-1:0];
        end
        if (wvalid && wready) begin
            next_wHeld = 1'b1;
            next_wready = 1'b0;
            next_wData = wdata;
            next_wStrb = wstrb;
        end
        // both held: write and answer
        if (doWrite) begin
            next_bvalid = 1'b1;
            next_bresp = wrHit ? RESP_OKAY : RESP_SLVERR;
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
        end
        // answer taken: ready again
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
        // read: answer one cycle after the address
        if (arvalid && arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h00000000;
            case (araddr[ADDR_W-1:0])
                OFS_FIRST_CONTROL_LOW: next_rdata[15:0] = firstControlLow;
                OFS_FIRST_CONTROL_HIGH: next_rdata[15:0] = firstControlHigh;
                OFS_SECOND_CONTROL_HIGH: next_rdata[15:0] = secondControlHigh;
                OFS_COUNT_LOW_HALF: next_rdata[15:0] = countLowHalf;
                OFS_COUNT_HIGH_HALF: next_rdata[15:0] = countHighHalf;
                OFS_PERIOD_LOW_HALF: next_rdata[15:0] = periodLowHalf;
                OFS_PERIOD_HIGH_HALF: next_rdata[15:0] = periodHighHalf;
                OFS_COMPARE_VALUE_A: next_rdata[15:0] = compareValueA;
                OFS_STATUS: begin
                    next_rdata[ST_ARMED] = armed;
                    next_rdata[ST_ROLL] = rollFlag;
                    next_rdata[ST_CMP] = cmpFlag;
                    next_rdata[ST_PIN] = compareOutputPin;
                end
                default: next_rresp = RESP_SLVERR; // unmapped reads zero
            endcase
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    // ************************************************
    // timer, compare and register next values
    // ************************************************
    always_comb begin
        next_ctlLow = firstControlLow;
        next_ctlHigh = firstControlHigh;
        next_ctl2High = secondControlHigh;
        next_perLow = periodLowHalf;
        next_perHigh = periodHighHalf;
        next_cmpA = compareValueA;
        next_cntLow = countLowHalf;
        next_cntHigh = countHighHalf;
        next_armed = armed;
        next_pendToggle = pendToggle;
        next_pin = compareOutputPin;
        // counting: rollover clears both halves in the same cycle
        if (rollNow) begin
            next_cntLow = RST_HALF; // RQ11
            next_cntHigh = RST_HALF; // RQ11
        end else if (running && wide) begin
            {next_cntHigh, next_cntLow} = fullCount + 32'h00000001; // RQ5
        end else if (running) begin
            next_cntLow = countLowHalf + 16'h0001;
        end
        // one-shot disarms on its match
        if (matchFire && oneShot) begin
            next_armed = 1'b0;
        end
        // aligned output waits for the period edge, unaligned toggles at once
        if (alignOn) begin
            // pending toggle lands on the first period edge too, no period is lost
            if (rollNow) begin
                next_pin = compareOutputPin ^ (pendToggle ^ matchFire); // RQ1 RQ2
                next_pendToggle = 1'b0;
            end else begin
                next_pendToggle = pendToggle ^ matchFire; // RQ2
            end
        end else begin
            next_pin = compareOutputPin ^ matchFire;
            next_pendToggle = 1'b0;
        end
        // register writes win over counting
        if (doWrite) begin
            case (wAddr)
                OFS_FIRST_CONTROL_LOW: next_ctlLow = merge16(firstControlLow, wData, wStrb);
                OFS_FIRST_CONTROL_HIGH: next_ctlHigh = merge16(firstControlHigh, wData, wStrb);
                OFS_SECOND_CONTROL_HIGH: next_ctl2High = merge16(secondControlHigh, wData, wStrb);
                OFS_COUNT_LOW_HALF: next_cntLow = merge16(countLowHalf, wData, wStrb);
                OFS_COUNT_HIGH_HALF: next_cntHigh = merge16(countHighHalf, wData, wStrb);
                OFS_PERIOD_LOW_HALF: next_perLow = merge16(periodLowHalf, wData, wStrb);
                OFS_PERIOD_HIGH_HALF: next_perHigh = merge16(periodHighHalf, wData, wStrb);
                OFS_COMPARE_VALUE_A: next_cmpA = merge16(compareValueA, wData, wStrb);
                OFS_STATUS: begin
                    if (wStrb[0] && wData[ST_DISARM]) begin
                        next_armed = 1'b0;
                    end
                    if (wStrb[0] && wData[ST_ARMED]) begin
                        next_armed = 1'b1;
                    end
                end
                default: next_armed = next_armed; // unmapped write changes nothing
            endcase
        end
        // sticky flags: hardware set wins over software clear
        next_rollFlag = rollNow || (rollFlag && !(doWrite && wAddr == OFS_STATUS &&
                        wStrb[0] && wData[ST_ROLL])); // RQ11
        next_cmpFlag = next_compareEvent || (cmpFlag && !(doWrite && wAddr == OFS_STATUS &&
                       wStrb[0] && wData[ST_CMP]));
    end

    // event outputs, each a one-cycle pulse
    always_comb begin
        next_special = specialSel && matchFire; // RQ4
        next_compareEvent = specialSel ? matchFire : postFire; // RQ3
        next_rollover = rollNow; // RQ11
    end

    // ************************************************
    // state registers
    // ************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            wAddr <= '0;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
            firstControlLow <= RST_HALF;
            firstControlHigh <= RST_HALF;
            secondControlHigh <= RST_HALF;
            countLowHalf <= RST_HALF;
            countHighHalf <= RST_HALF;
            periodLowHalf <= RST_PERIOD;
            periodHighHalf <= RST_PERIOD;
            compareValueA <= RST_HALF;
            armed <= 1'b0;
            rollFlag <= 1'b0;
            cmpFlag <= 1'b0;
            pendToggle <= 1'b0;
            compareOutputPin <= 1'b0;
            specialEventPulse <= 1'b0;
            compareEvent <= 1'b0;
            rolloverEvent <= 1'b0;
        end else begin
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            wAddr <= next_wAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            firstControlLow <= next_ctlLow;
            firstControlHigh <= next_ctlHigh;
            secondControlHigh <= next_ctl2High;
            countLowHalf <= next_cntLow;
            countHighHalf <= next_cntHigh;
            periodLowHalf <= next_perLow;
            periodHighHalf <= next_perHigh;
            compareValueA <= next_cmpA;
            armed <= next_armed;
            rollFlag <= next_rollFlag;
            cmpFlag <= next_cmpFlag;
            pendToggle <= next_pendToggle;
            compareOutputPin <= next_pin;
            specialEventPulse <= next_special;
            compareEvent <= next_compareEvent;
            rolloverEvent <= next_rollover;
        end
    end

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_roll_clears_count: assert property (rollNow && !doWrite |=> fullCount == 32'h0 && rollFlag) // RQ11
        else $error("rollover did not clear the count and set the flag");
    a_roll_event_pulse: assert property (rollNow |=> rolloverEvent) // RQ11
        else $error("rollover event missing");
    a_no_early_wrap: assert property (running && wide && countLowHalf == 16'hffff && countHighHalf != 16'hffff
        && !rollNow && !doWrite |=> countHighHalf == $past(countHighHalf) + 16'h0001) // RQ7
        else $error("wide timer rolled over at the low half wrap");
    a_wrap_at_ones: assert property (running && wide && fullCount == FULL_ONES && !doWrite |=>
        fullCount == 32'h0 ##0 rolloverEvent) // RQ8
        else $error("wide timer did not roll over at all ones");
    a_wide_carry: assert property (running && wide && !rollNow && !doWrite |=>
        fullCount == $past(fullCount) + 32'h1) // RQ5
        else $error("wide timer did not count as one 32-bit value");
    a_sync_no_match: assert property (running && firstControlHigh[SYNC_HI:SYNC_LO] != SYNC_FREE
        && !wrapHit && !syncRise |-> !rollNow) // RQ6
        else $error("period match used with an external sync source");
    a_special_each: assert property (specialSel && matchFire |=> specialEventPulse && compareEvent) // RQ4 RQ3
        else $error("special event missed a compare match");
    a_aligned_pin: assert property (alignOn && !rollNow |=> compareOutputPin == $past(compareOutputPin)) // RQ1 RQ2
        else $error("aligned output changed off the period edge");
    a_oneshot_once: assert property (oneShot && matchFire && !doWrite |=> !armed) // RQ9
        else $error("one-shot compare stayed armed");
    c_wide_roll: cover property (wide && rollNow);
    c_special_pulse: cover property (specialEventPulse);
    c_aligned_toggle: cover property (alignOn && rollNow && pendToggle);
    c_oneshot_fire: cover property (oneShot && matchFire);
endmodule : compare_timer

// *** tb_top.sv ***
// self-checking bench of the compare timer block
`timescale 1ns/1ns
module tb_top;
    import compare_timer_pkg::*;
    // ******** stimulus and observed signals ********
    logic clk = 0, nrst = 0, syncPin = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rdVal;
    logic [3:0] wstrb = 4'h3; // only the 16-bit lanes
    logic [1:0] bresp, rresp, wrResp, rdResp;
    logic awready, wready, bvalid, arready, rvalid, compareOutputPin, specialEventPulse, compareEvent, rolloverEvent;
    logic p0; // pin level before alignment test
    int fail_count = 0, n_compared = 0, c;
    always #10 clk = ~clk; // 50 MHz
    compare_timer dut_u (.clk(clk), .nrst(nrst), .syncPin(syncPin), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .compareOutputPin(compareOutputPin),
        .specialEventPulse(specialEventPulse), .compareEvent(compareEvent), .rolloverEvent(rolloverEvent));
    // ******** verdict, compare and bus tasks ********
    task automatic test_done;
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // write one register; address and data held until each is taken
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        int i;
        @(posedge clk);
        awaddr <= {26'h0, a}; wdata <= {16'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 0;
            if (wvalid && wready === 1'b1) wvalid <= 0;
            if (bvalid === 1'b1) begin
                wrResp = bresp; bready <= 0; break;
            end
        end
        if (i == 50) begin fail_count++; test_done(); end // no answer
    endtask : wr
    // read one register
    task automatic rd(input logic [5:0] a);
        int i;
        @(posedge clk);
        araddr <= {26'h0, a}; arvalid <= 1; rready <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (arvalid && arready === 1'b1) arvalid <= 0;
            if (rvalid === 1'b1) begin
                rdVal = rdata; rdResp = rresp; rready <= 0; break;
            end
        end
        if (i == 50) begin fail_count++; test_done(); end // no answer
    endtask : rd
    // count one-cycle pulses of an event output over n cycles
    task automatic cnt(input int sel, input int n);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            c += (sel == 0) ? (rolloverEvent === 1'b1) :
                 (sel == 1) ? (specialEventPulse === 1'b1) : (compareEvent === 1'b1);
        end
    endtask : cnt
    // wait for a rollover under a bound
    task automatic wait_roll;
        int i;
        for (i = 0; i < 100 && rolloverEvent !== 1'b1; i++) @(posedge clk);
        if (i == 100) begin fail_count++; test_done(); end
    endtask : wait_roll
    // ******** scenarios ********
    task automatic t_reset; // reset values, unmapped place refused
        rd(OFS_PERIOD_LOW_HALF); chk(rdVal, 32'h0000ffff);
        rd(6'h3c); chk(rdResp, RESP_SLVERR);
        chk(rdVal, 32'h00000000);
        wr(6'h3c, 16'h1234); chk(wrResp, RESP_SLVERR);
    endtask : t_reset
    task automatic t_period; // free match at period 5 gives a 6-cycle rollover interval
        wr(OFS_COMPARE_VALUE_A, 16'h0002); wr(OFS_PERIOD_LOW_HALF, 16'h0005); wr(OFS_FIRST_CONTROL_LOW, 16'h8000);
        wait_roll(); @(posedge clk); cnt(0, 60); chk(c, 10);
        rd(OFS_STATUS); chk(rdVal & 32'h00000006, 32'h00000006);
    endtask : t_period
    task automatic t_special; // postscaler ignored with special event, used without
        wr(OFS_FIRST_CONTROL_HIGH, 16'h0380); cnt(1, 60); chk(c, 10);
        cnt(2, 60); chk(c, 10);
        wr(OFS_FIRST_CONTROL_HIGH, 16'h0100); repeat (3) @(posedge clk);
        cnt(2, 60); chk(c, 5);
        cnt(1, 60); chk(c, 0);
    endtask : t_special
    task automatic t_sync; // external sync source: no period match, rollover on the sync edge only
        wr(OFS_FIRST_CONTROL_HIGH, 16'h0001); cnt(0, 30); chk(c, 0);
        syncPin <= 1; cnt(0, 10); chk(c, 1);
        syncPin <= 0;
    endtask : t_sync
    task automatic t_wide; // high halves equal, low above period: no wrap at low FFFF
        wr(OFS_FIRST_CONTROL_LOW, 16'h0000); wr(OFS_FIRST_CONTROL_HIGH, 16'h0000);
        wr(OFS_COUNT_HIGH_HALF, 16'h1000); wr(OFS_PERIOD_HIGH_HALF, 16'h1000);
        wr(OFS_PERIOD_LOW_HALF, 16'h0000); wr(OFS_COUNT_LOW_HALF, 16'hfff0);
        wr(OFS_FIRST_CONTROL_LOW, 16'h8020); cnt(0, 40); chk(c, 0);
        rd(OFS_COUNT_HIGH_HALF); chk(rdVal, 32'h00001001);
    endtask : t_wide
    task automatic t_align; // aligned pin toggles already in the first period
        wr(OFS_FIRST_CONTROL_LOW, 16'h0000); wr(OFS_PERIOD_HIGH_HALF, 16'hffff);
        wr(OFS_PERIOD_LOW_HALF, 16'h0005); wr(OFS_COUNT_LOW_HALF, 16'h0000); wr(OFS_COUNT_HIGH_HALF, 16'h0000);
        wr(OFS_SECOND_CONTROL_HIGH, 16'h8000); p0 = compareOutputPin;
        wr(OFS_FIRST_CONTROL_LOW, 16'h8000); wait_roll(); @(posedge clk);
        chk(compareOutputPin, !p0);
        @(posedge clk); wait_roll(); @(posedge clk); chk(compareOutputPin, p0);
    endtask : t_align
    task automatic t_oneshot; // armed shot fires once; zero compare after disarm and count reset: no extra event
        wr(OFS_FIRST_CONTROL_LOW, 16'h0000); wr(OFS_COMPARE_VALUE_A, 16'h0000);
        wr(OFS_FIRST_CONTROL_LOW, 16'h8010); wr(OFS_STATUS, 16'h0001);
        cnt(2, 30); chk(c, 1);
        wr(OFS_STATUS, 16'h0010); wr(OFS_COUNT_LOW_HALF, 16'h0000);
        cnt(2, 30); chk(c, 0);
        wr(OFS_COMPARE_VALUE_A, 16'h0001); wr(OFS_STATUS, 16'h0001);
        cnt(2, 30); chk(c, 1);
    endtask : t_oneshot
    // ******** main sequence ********
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1;
        t_reset(); t_period(); t_special(); t_sync(); t_wide(); t_align(); t_oneshot();
        test_done();
    end
endmodule : tb_top
